// File: sac_pkg.sv
package sac_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ  = 100;
  localparam int CS_FILT_NS   = 1425;
  localparam int CONV_NS      = 21000;
  localparam int ABORT_NS     = 9000;
  // least times round up, longest times round down
  localparam int CS_FILT_CYC  = (CS_FILT_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int CONV_CYC     = (CONV_NS * SYS_CLK_MHZ) / 1000;
  localparam int ABORT_CYC    = (ABORT_NS * SYS_CLK_MHZ) / 1000;
  localparam int TMR_W        = 12;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int RES_W        = 10;
  localparam int ADDR_W       = 4;
  localparam int CNT_W        = 5;
  localparam logic [CNT_W-1:0] ADDR_EDGES = 5'h04;
  localparam logic [CNT_W-1:0] CONV_EDGE  = 5'h0a;
  localparam logic [CNT_W-1:0] CNT_MAX    = 5'h10;

  // ----------------------------------------------------------------
  // channel codes and fixed results
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CH_TEST_MID  = 4'hb;
  localparam logic [ADDR_W-1:0] CH_TEST_LOW  = 4'hc;
  localparam logic [ADDR_W-1:0] CH_TEST_HIGH = 4'hd;
  localparam logic [RES_W-1:0]  CODE_MID     = 10'h200;
  localparam logic [RES_W-1:0]  CODE_ZERO    = 10'h000;
  localparam logic [RES_W-1:0]  CODE_FULL    = 10'h3ff;

  typedef struct packed {
    logic [RES_W-1:0] code;
    logic             over;
    logic             under;
  } sac_core_type;

  typedef enum logic [0:0] {
    SAC_IDLE,
    SAC_CONV
  } sac_state_type;

endpackage

// File: sac_top.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// R01: self-test channels 1011, 1100, 1101 return 512, 0 and 1023.
// R02: channel address and result are plain positive-logic binary.
// R03: above upper reference gives all ones; below lower gives all zeros.
// R04: whole cycle fits in 21 us conversion plus ten serial clocks.
// R05: channel is sampled at most six serial clocks before conversion.
// R06: end-of-conversion falls within 240 ns after tenth falling serial edge.
// R07: MSB appears on data out within 100 ns of end-of-conversion rising.
// R08: each later data bit updates after a falling edge, valid within 240 ns.
// R09: chip select low drives MSB on data out within 1.3 us.
// R10: chip select high releases data out within 150 ns.
// R11: chip select falling within 9 us of conversion start aborts it.
// R12: chip select change accepted only after holding 1.425 us.
// R13: host waits out chip select setup before clocking address bits.
// R14: long transfers need a serial rising edge within 9.5 us of tenth fall.
// R15: host gives the 11th rising edge before conversion finishes.
// R16: without chip select, next transfer starts after end-of-conversion rises.
// R17: chip select high stops address and serial clock within the filter time.
// R18: address captured MSB first on the first four rising serial edges.
// R19: previous result shifted out MSB first during the next transfer.
module sac_top (
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_io_clk,
  input  wire logic                 i_cs_n,
  input  wire logic                 i_addr,
  input  wire sac_pkg::sac_core_type i_core,
  output logic                      o_data,
  output logic                      o_data_oe,
  output logic                      o_eoc,
  output logic [sac_pkg::ADDR_W-1:0] o_mux_sel,
  output logic                      o_sample
);

  // ----------------------------------------------------------------
  // link domain: serial clock edges
  // ----------------------------------------------------------------
  logic                        lnk_clr;
  logic                        lnk_rst_n;
  logic [sac_pkg::CNT_W-1:0]   rise_cnt;
  logic [sac_pkg::CNT_W-1:0]   fall_cnt;
  logic [sac_pkg::CNT_W-1:0]   fall_gray;
  logic [sac_pkg::ADDR_W-1:0]  addr_sh;
  logic                        conv_tgl;

  // clear comes from a sys flop, so the gated reset is glitch free;
  // the link clock is idle whenever the clear is released
  assign lnk_rst_n = i_resetn & ~lnk_clr;

  always_ff @(posedge i_io_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      rise_cnt <= '0;
    end else if (rise_cnt != sac_pkg::CNT_MAX) begin
      rise_cnt <= rise_cnt + 5'h01;
    end
  end

  always_ff @(posedge i_io_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      addr_sh <= '0;
    end else if (rise_cnt < sac_pkg::ADDR_EDGES) begin
      addr_sh <= {addr_sh[sac_pkg::ADDR_W-2:0], i_addr}; // R18 R02
    end
  end

  always_ff @(negedge i_io_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      fall_cnt  <= '0;
      fall_gray <= '0;
    end else if (fall_cnt != sac_pkg::CNT_MAX) begin
      fall_cnt  <= fall_cnt + 5'h01;
      // gray so the sys side sees one bit move per edge R08
      fall_gray <= (fall_cnt + 5'h01) ^ ((fall_cnt + 5'h01) >> 1);
    end
  end

  // toggle survives the frame clear so a start event is never lost
  always_ff @(negedge i_io_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      conv_tgl <= 1'b0;
    end else if (lnk_rst_n && fall_cnt == sac_pkg::CONV_EDGE - 5'h01) begin
      conv_tgl <= ~conv_tgl; // R06
    end
  end

  // ----------------------------------------------------------------
  // sys domain: synchronisers
  // ----------------------------------------------------------------
  logic                        cs_s;
  logic                        tgl_s;
  logic                        tgl_q;
  logic [sac_pkg::CNT_W-1:0]   gray_s;
  logic [sac_pkg::CNT_W-1:0]   bit_idx;

  // pin resets high so the part looks deselected from the start
  sac_sync #(
    .W   (1),
    .RST (1'b1)
  ) i_sync_cs (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      (i_cs_n),
    .o_q      (cs_s)
  );

  sac_sync #(
    .W (1)
  ) i_sync_tgl (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      (conv_tgl),
    .o_q      (tgl_s)
  );

  // gray code: only one bit moves per falling edge, so a multi-bit sync is safe
  sac_sync #(
    .W (sac_pkg::CNT_W)
  ) i_sync_gray (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      (fall_gray),
    .o_q      (gray_s)
  );

  // extra flop for edge detection only, behind the synchroniser
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tgl_q <= 1'b0;
    end else begin
      tgl_q <= tgl_s;
    end
  end

  logic conv_start;
  assign conv_start = tgl_s ^ tgl_q;

  // ----------------------------------------------------------------
  // chip select filter
  // ----------------------------------------------------------------
  logic                     cs_filt;
  logic [sac_pkg::TMR_W-1:0] cs_tmr;
  logic                     cs_fall;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_filt <= 1'b1;
      cs_tmr  <= '0;
    end else if (cs_s == cs_filt) begin
      cs_tmr <= '0;
    end else if (cs_tmr == sac_pkg::TMR_W'(sac_pkg::CS_FILT_CYC - 1)) begin
      cs_filt <= cs_s; // R12
      cs_tmr  <= '0;
    end else begin
      cs_tmr <= cs_tmr + 12'h001;
    end
  end

  assign cs_fall = cs_filt && (cs_tmr == sac_pkg::TMR_W'(sac_pkg::CS_FILT_CYC - 1)) && !cs_s;

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  sac_pkg::sac_state_type    state;
  logic [sac_pkg::TMR_W-1:0] conv_tmr;
  logic [sac_pkg::RES_W-1:0] result;
  logic                      conv_done;
  logic                      abort_hit;

  assign conv_done = (state == sac_pkg::SAC_CONV)
                   && (conv_tmr == sac_pkg::TMR_W'(sac_pkg::CONV_CYC - 1));

  // abort only counts inside the window after conversion start
  assign abort_hit = cs_fall && (conv_tmr < sac_pkg::TMR_W'(sac_pkg::ABORT_CYC));

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state     <= sac_pkg::SAC_IDLE;
      conv_tmr  <= '0;
      o_mux_sel <= '0;
    end else begin
      unique case (state)
        sac_pkg::SAC_IDLE: begin
          conv_tmr <= '0;
          if (conv_start) begin
            // address has been stable since the fourth rising edge
            o_mux_sel <= addr_sh;
            state     <= sac_pkg::SAC_CONV;
          end
        end
        sac_pkg::SAC_CONV: begin
          conv_tmr <= conv_tmr + 12'h001;
          if (abort_hit) begin
            state <= sac_pkg::SAC_IDLE; // R11
          end else if (conv_done) begin
            state <= sac_pkg::SAC_IDLE; // R04
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      result <= '0;
    end else if (conv_done) begin
      // an abort can never coincide with the done count, so no late discard
      if (o_mux_sel == sac_pkg::CH_TEST_MID) begin
        result <= sac_pkg::CODE_MID; // R01
      end else if (o_mux_sel == sac_pkg::CH_TEST_LOW) begin
        result <= sac_pkg::CODE_ZERO; // R01
      end else if (o_mux_sel == sac_pkg::CH_TEST_HIGH) begin
        result <= sac_pkg::CODE_FULL; // R01
      end else if (i_core.over) begin
        result <= sac_pkg::CODE_FULL; // R03
      end else if (i_core.under) begin
        result <= sac_pkg::CODE_ZERO; // R03
      end else begin
        result <= i_core.code; // R02
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_eoc <= 1'b1;
    end else begin
      o_eoc <= !(conv_start || (state == sac_pkg::SAC_CONV && !conv_done
                && !abort_hit)); // R06 R07
    end
  end

  // sampling runs from the fourth falling edge to the tenth falling edge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sample <= 1'b0;
    end else begin
      o_sample <= (state == sac_pkg::SAC_IDLE) && !lnk_clr
                  && (bit_idx >= sac_pkg::ADDR_EDGES)
                  && (bit_idx < sac_pkg::CONV_EDGE); // R05
    end
  end

  // frame clear: filtered high chip select, or conversion end R16 R17
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lnk_clr <= 1'b1;
    end else begin
      lnk_clr <= cs_filt || conv_done;
    end
  end

  // ----------------------------------------------------------------
  // data out
  // ----------------------------------------------------------------
  always_comb begin
    bit_idx = gray_s;
    for (int i = sac_pkg::CNT_W - 2; i >= 0; i--) begin
      bit_idx[i] = bit_idx[i+1] ^ gray_s[i];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_data    <= 1'b0;
      o_data_oe <= 1'b0;
    end else begin
      // enable follows the raw synchronised pin; the filter is too slow
      o_data_oe <= !cs_s; // R09 R10
      if (bit_idx < sac_pkg::CNT_W'(sac_pkg::RES_W)) begin
        o_data <= result[4'(sac_pkg::RES_W - 1) - bit_idx[3:0]]; // R19 R07 R08
      end else begin
        o_data <= 1'b0;
      end
    end
  end

endmodule

// ----------------------------------------------------------------
// two-flop synchroniser
// ----------------------------------------------------------------
module sac_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta;

  // only the second flop is read outside this module
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta <= RST;
      o_q  <= RST;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule
`default_nettype wire

// File: sac_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sac_top_sva (
  input wire logic                        i_clk,
  input wire logic                        i_resetn,
  input wire logic                        i_cs_n,
  input wire logic                        o_data_oe,
  input wire logic                        o_eoc,
  input wire logic [sac_pkg::ADDR_W-1:0] o_mux_sel
);
  // ----
  // helper counters
  // ----
  logic [11:0] lo_cnt;
  logic [11:0] cs_cnt;
  logic        cs_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lo_cnt <= 12'h000;
    end else begin
      lo_cnt <= o_eoc ? 12'h000 : lo_cnt + 12'h001;
    end
  end
  // cycles since the pin last moved, saturating
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_q   <= 1'b1;
      cs_cnt <= 12'h000;
    end else begin
      cs_q   <= i_cs_n;
      cs_cnt <= (cs_q != i_cs_n) ? 12'h000 : cs_cnt + {11'h000, cs_cnt != 12'hfff};
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  a_oe_enable: assert property ($fell(i_cs_n) |-> ##[1:130] o_data_oe)
    else $error("data output not enabled after select");
  a_oe_release: assert property ($rose(i_cs_n) |-> ##[1:15] !o_data_oe)
    else $error("data output not released after deselect");
  a_oe_idle: assert property (i_cs_n [*4] |-> !o_data_oe)
    else $error("data output driven while deselected");
  a_sel_steady: assert property (!o_eoc && !$past(o_eoc) |-> $stable(o_mux_sel))
    else $error("channel changed during conversion");
  a_conv_bound: assert property (!o_eoc |-> lo_cnt < 12'd2103)
    else $error("conversion runs too long");
  a_conv_length: assert property ($rose(o_eoc) && i_cs_n |-> lo_cnt > 12'd2097)
    else $error("conversion ended early without abort");
  a_abort_window: assert property ($rose(o_eoc) && lo_cnt < 12'd2098
    |-> !i_cs_n && cs_cnt > 12'd142 && lo_cnt < 12'd905)
    else $error("early end without a valid abort");
  a_start_selected: assert property ($fell(o_eoc) |-> !i_cs_n || cs_cnt < 12'd150)
    else $error("conversion started while deselected");
endmodule
bind sac_top sac_top_sva i_sac_top_sva (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n),
  .o_data_oe(o_data_oe), .o_eoc(o_eoc), .o_mux_sel(o_mux_sel)
);
`default_nettype wire

// File: sac_host.sv
`timescale 1ns/1ps
`default_nettype none
module sac_host (
  input  wire logic i_data,
  input  wire logic i_data_oe,
  output logic      o_cs_n,
  output logic      o_io_clk,
  output logic      o_addr
);
  // ----
  // serial controller model
  // ----
  logic lclk = 1'b0;
  logic last = 1'b0;
  wire logic line;
  initial #4 forever #15 lclk = ~lclk;
  // a released line shows the inverse, so a stale bit never passes
  always @* if (i_data_oe) last = i_data;
  assign line = i_data_oe ? i_data : ~last;
  initial begin
    o_cs_n = 1'b1;
    o_io_clk = 1'b0;
    o_addr = 1'b0;
  end
  task automatic set_cs(input logic lvl);
    @(posedge lclk) #1 o_cs_n = lvl;
  endtask
  task automatic frame(input logic [3:0] a, input int n, output logic [9:0] d);
    set_cs(1'b0);
    repeat (60) @(posedge lclk);
    for (int i = 0; i < n; i++) begin
      @(posedge lclk) #1 o_addr = (i < 4) ? a[3-i] : 1'b0;
      @(posedge lclk) #1 o_io_clk = 1'b1;
      if (i < 10) d[9-i] = line;
      @(posedge lclk) #1 o_io_clk = 1'b0;
      repeat (9) @(posedge lclk);
    end
  endtask
endmodule
`default_nettype wire

// File: sac_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sac_top_bench;
  logic                       i_clk = 1'b0;
  logic                       i_resetn = 1'b0;
  sac_pkg::sac_core_type      core = '0;
  wire logic                  cs_n, io_clk, addr, data, data_oe, eoc, samp;
  wire logic [3:0]            sel;
  int                         n_errors = 0;
  int                         comparisons = 0;
  // core words are {code, over, under}
  logic [11:0] t_core [8] = '{0, 0, 0, 12'ha94, 12'ha96, 12'ha95, 12'h568, 12'h3fc};
  logic [3:0]  t_addr [8] = '{4'hb, 4'hc, 4'hd, 4'h3, 4'h5, 4'h6, 4'he, 4'hf};
  logic [9:0]  t_exp [8] = '{10'h000, sac_pkg::CODE_MID, sac_pkg::CODE_ZERO,
    sac_pkg::CODE_FULL, 10'h2a5, sac_pkg::CODE_FULL, sac_pkg::CODE_ZERO, 10'h15a};
  always #5 i_clk = ~i_clk;
  sac_top i_sac_top (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_io_clk(io_clk), .i_cs_n(cs_n), .i_addr(addr),
    .i_core(core), .o_data(data), .o_data_oe(data_oe), .o_eoc(eoc), .o_mux_sel(sel),
    .o_sample(samp)
  );
  sac_host i_sac_host (
    .i_data(data), .i_data_oe(data_oe), .o_cs_n(cs_n), .o_io_clk(io_clk), .o_addr(addr)
  );
  // ----
  // shared tasks
  // ----
  task automatic check(input logic [11:0] act, input logic [11:0] exp);
    comparisons++;
    if (act !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task automatic xfer(input logic [3:0] a, input int n, output logic [9:0] d);
    int k;
    i_sac_host.frame(a, n, d);
    i_sac_host.set_cs(1'b1);
    check({11'h000, eoc}, 12'h000);
    check({11'h000, samp}, 12'h000);
    check({8'h00, sel}, {8'h00, a});
    k = 0;
    while (eoc !== 1'b1 && k < 2300) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    check({11'h000, eoc}, 12'h001);
  endtask
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_channels;
    logic [9:0] d;
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk) #1 core = t_core[i];
      xfer(t_addr[i], 10 + (i % 7), d);
      check({2'h0, d}, {2'h0, t_exp[i]});
    end
  endtask
  task automatic t_abort;
    logic [9:0] d;
    @(posedge i_clk) #1 core = 12'h0f0;
    i_sac_host.frame(4'h7, 10, d);
    i_sac_host.set_cs(1'b1);
    repeat (200) @(posedge i_clk);
    i_sac_host.set_cs(1'b0);
    repeat (50) @(posedge i_clk);
    i_sac_host.set_cs(1'b1);
    repeat (200) @(posedge i_clk);
    #1;
    check({11'h000, eoc}, 12'h000);
    i_sac_host.set_cs(1'b0);
    repeat (300) @(posedge i_clk);
    #1;
    check({11'h000, eoc}, 12'h001);
    check({11'h000, data_oe}, 12'h001);
    xfer(4'h2, 10, d);
    check({2'h0, d}, 12'h0ff);
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    t_channels();
    t_abort();
    give_verdict();
  end
  // ten frames of about 30 us each, with double margin
  initial begin
    #600000;
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
